// *** logic/adsc_pkg.sv ***
// Shared constants and types for the converter sequencing control block.
package adsc_pkg;

   // APB address width and data width seen by the register slave.
   localparam int unsigned APB_ADDR_W = 12;
   localparam int unsigned APB_DATA_W = 32;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [9:0] CSR_IDX = 10'h070;
   localparam logic [9:0] RES_HIGH_IDX = 10'h071;
   localparam logic [9:0] RES_LOW_IDX = 10'h072;

   // Field positions inside the control/status register.
   localparam int unsigned DONE_BIT = 7;
   localparam int unsigned SPEED_BIT = 6;
   localparam int unsigned ON_BIT = 5;
   localparam int unsigned RSVD_BIT = 4;
   localparam int unsigned CH_LSB = 0;
   localparam int unsigned CH_W = 4;

   // Result width and the split between the two result registers.
   localparam int unsigned RES_BITS = 10;
   localparam int unsigned RES_HIGH_LSB = 2;

   // Reset values of the registers.
   localparam logic [7:0] CSR_RST = 8'h00;
   localparam logic [9:0] RES_RST = 10'h000;

   // Converter timing: sampling ticks and the slow divide exponent (2**2 = 4).
   localparam int unsigned SAMPLE_TICKS = 2;
   localparam int unsigned SLOW_DIV_W = 2;

   // Stabilisation after leaving halt, in ns, and its cycle count at 125 MHz (rounded up).
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned STAB_NS = 1000;
   localparam int unsigned STAB_CYCLES = (STAB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Software view of the control/status register.
   typedef struct packed {
      logic done;
      logic fast;
      logic on;
      logic [CH_W-1:0] ch;
   } adsc_csr_t;

   // Signals that steer the analog multiplexer and converter core.
   typedef struct packed {
      logic power;
      logic sample;
      logic adc_clk;
      logic [CH_W-1:0] channel;
   } adsc_analog_t;

   // Sequencer states, Gray coded along off, sample, convert.
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV = 2'b11
   } adsc_state_t;

endpackage

// *** logic/adsc_clkdiv.sv ***
`timescale 1ns/1ps
// Converter clock divider: one tick per converter clock period.
module adsc_clkdiv
   import adsc_pkg::*;
#(
   parameter int unsigned DIV_W = SLOW_DIV_W
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic run_i,
   input wire logic fast_i,
   output logic tick_o,
   output logic phase_o
);

   // Free counter of CPU cycles; held at zero while stopped so restarts align.
   logic [DIV_W-1:0] cnt_reg;

   // The fast divide by two needs one counter bit, the slow one needs DIV_W.
   if (DIV_W < 2) begin : g_check
      $error("adsc_clkdiv: DIV_W must be at least 2");
   end

   // Counter advances only while the converter runs.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
      end else if (!run_i) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // The tick marks the last CPU cycle of each converter period.
   assign tick_o = run_i & (fast_i ? cnt_reg[0] : (&cnt_reg));
   // Square converter clock level for the analog core.
   assign phase_o = fast_i ? cnt_reg[0] : cnt_reg[DIV_W-1];

endmodule

// *** logic/adsc_ctrl.sv ***
`timescale 1ns/1ps
module adsc_ctrl
   import adsc_pkg::*;
#(
   parameter int unsigned SAMPLE_LEN = SAMPLE_TICKS,
   parameter int unsigned STAB_LEN = STAB_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_ADDR_W-1:0] paddr_i,
   input wire logic [APB_DATA_W-1:0] pwdata_i,
   output logic [APB_DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic halt_i,
   input wire logic [RES_BITS-1:0] core_data_i,
   output adsc_analog_t analog_o
);

   // Width of the stabilisation counter and of the phase tick counter.
   localparam int unsigned STAB_W = $clog2(STAB_LEN + 1);
   localparam int unsigned CNT_W = 4;
   localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_LEN - 1);
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(RES_BITS - 1);

   // Counts must fit the four-bit phase counter and be at least one tick.
   if (SAMPLE_LEN < 1 || SAMPLE_LEN > 16 || RES_BITS > 16 || STAB_LEN < 1) begin : g_check
      $error("adsc_ctrl: timing parameters out of range");
   end

   // Register state.
   adsc_csr_t csr_reg;                // Control/status register.
   logic [RES_BITS-1:0] result_reg;   // Last completed conversion.
   adsc_state_t state_reg;            // Sequencer state.
   logic [CNT_W-1:0] cnt_reg;         // Ticks spent in the current phase.
   logic [STAB_W-1:0] stab_reg;       // Cycles left before conversions are trusted.
   logic [RES_BITS-1:0] core_meta_reg; // First synchroniser stage of core data.
   logic [RES_BITS-1:0] core_sync_reg; // Second synchroniser stage of core data.
   logic [APB_DATA_W-1:0] prdata_reg; // Registered read data.
   logic pready_reg;                  // Registered ready, one cycle per transfer.
   logic pslverr_reg;                 // Registered error for unmapped addresses.
   adsc_analog_t analog_reg;          // Registered analog steering.

   // Next values.
   adsc_state_t state_next;
   logic [CNT_W-1:0] cnt_next;

   // APB phase decode: the first access cycle latches data, the second completes.
   wire access_first = psel_i & penable_i & ~pready_reg;
   wire xfer_done = psel_i & penable_i & pready_reg;
   wire word_ok = (paddr_i[1:0] == 2'b00);
   wire hit_csr = word_ok & (paddr_i[11:2] == CSR_IDX);
   wire hit_high = word_ok & (paddr_i[11:2] == RES_HIGH_IDX);
   wire hit_low = word_ok & (paddr_i[11:2] == RES_LOW_IDX);
   wire hit_any = hit_csr | hit_high | hit_low;
   wire wr_csr = xfer_done & pwrite_i & hit_csr;
   wire rd_high = xfer_done & ~pwrite_i & hit_high;

   // Written control fields; bit 7 and reserved bit 4 are not writable.
   wire [CH_W-1:0] wr_ch = pwdata_i[CH_LSB +: CH_W];
   wire wr_on = pwdata_i[ON_BIT];
   wire on_next = wr_csr ? wr_on : csr_reg.on;
   wire fast_next = wr_csr ? pwdata_i[SPEED_BIT] : csr_reg.fast;
   wire [CH_W-1:0] ch_next = wr_csr ? wr_ch : csr_reg.ch;
   wire ch_change = wr_csr & (wr_ch != csr_reg.ch);
   wire restart = ch_change | (wr_csr & wr_on & ~csr_reg.on);
   wire go = on_next & ~halt_i & (stab_reg == '0);

   // Converter clock ticks from the divider.
   logic tick;
   logic adc_phase;
   wire div_run = (state_reg != ST_OFF) & ~restart;

   adsc_clkdiv #(
      .DIV_W(SLOW_DIV_W)
   ) u_clkdiv (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .run_i(div_run),
      .fast_i(csr_reg.fast),
      .tick_o(tick),
      .phase_o(adc_phase)
   );

   // A conversion completes on the last bit tick unless it is aborted that cycle.
   // sample plus bit ticks
   wire end_conv = (state_reg == ST_CONV) & tick & (cnt_reg == CONV_LAST) & go & ~restart;

   wire done_next = end_conv | (csr_reg.done & ~(wr_csr | rd_high));

   // Read mux; reserved bit 4 and result_low bits 7:2 read as zero.
   wire [7:0] csr_view = {csr_reg.done, csr_reg.fast, csr_reg.on, 1'b0, csr_reg.ch};
   wire [7:0] high_view = result_reg[RES_BITS-1:RES_HIGH_LSB];
   wire [7:0] low_view = {6'h00, result_reg[RES_HIGH_LSB-1:0]};
   wire [7:0] rd_byte = hit_csr ? csr_view : (hit_high ? high_view : (hit_low ? low_view : 8'h00));

   // Sequencer: sample for SAMPLE_LEN ticks, then one tick per result bit, then again.
   // no dependence on wait
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (!go) begin
         state_next = ST_OFF;
         cnt_next = '0;
      end else if (restart || state_reg == ST_OFF) begin
         state_next = ST_SAMPLE;
         cnt_next = '0;
      end else if (tick) begin
         case (state_reg)
            ST_SAMPLE: begin
               if (cnt_reg == SAMPLE_LAST) begin
                  state_next = ST_CONV;
                  cnt_next = '0;
               end else begin
                  cnt_next = cnt_reg + 4'h1;
               end
            end
            ST_CONV: begin
               if (cnt_reg == CONV_LAST) begin
                  state_next = ST_SAMPLE;
                  cnt_next = '0;
               end else begin
                  cnt_next = cnt_reg + 4'h1;
               end
            end
            default: begin
               state_next = ST_OFF;
               cnt_next = '0;
            end
         endcase
      end
   end

   // Sequencer registers.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_OFF;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Stabilisation counter: reloaded through halt, counts down after wake-up.
   // stabilisation countdown
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stab_reg <= '0;
      end else if (halt_i) begin
         stab_reg <= STAB_W'(STAB_LEN);
      end else if (stab_reg != '0) begin
         stab_reg <= stab_reg - {{(STAB_W-1){1'b0}}, 1'b1};
      end
   end

   // Core data comes from the analog side, so it is synchronised before use.
   // Saturation above or below the references is produced by the core itself.
   // saturation passes through
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         core_meta_reg <= RES_RST;
         core_sync_reg <= RES_RST;
      end else begin
         core_meta_reg <= core_data_i;
         core_sync_reg <= core_meta_reg;
      end
   end

   // Control/status and result registers.
   // reset clears registers
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         csr_reg <= adsc_csr_t'({CSR_RST[7:5], CSR_RST[CH_W-1:0]});
         result_reg <= RES_RST;
      end else begin
         csr_reg.done <= done_next;
         csr_reg.fast <= fast_next;
         csr_reg.on <= on_next;
         csr_reg.ch <= ch_next;
         if (end_conv) begin
            result_reg <= core_sync_reg;
         end
      end
   end

   // APB slave: one wait state, then ready for a single cycle.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else if (access_first) begin
         prdata_reg <= pwrite_i ? '0 : {24'h000000, rd_byte};
         pready_reg <= 1'b1;
         pslverr_reg <= ~hit_any;
      end else begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // Analog steering is registered so the core sees glitch-free levels.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         analog_reg <= '0;
      end else begin
         analog_reg.power <= go;
         analog_reg.sample <= (state_next == ST_SAMPLE);
         analog_reg.adc_clk <= adc_phase;
         analog_reg.channel <= ch_next;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign analog_o = analog_reg;

   // Checks on the sequencer and the register file.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_high_read;
      access_first & ~pwrite_i & hit_high;
   endsequence

   sequence s_read_back;
      ##1 (pready_o && prdata_o[7:0] == $past(result_reg[9:2]));
   endsequence

   property p_done_on_end;
      end_conv |=> (csr_reg.done && result_reg == $past(core_sync_reg));
   endproperty
   a_done_on_end: assert property (p_done_on_end) else $error("flag not set at end");

   property p_read_clears;
      (rd_high && !end_conv) |=> !csr_reg.done;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flag kept after read");

   property p_off_powers_down;
      !on_next |=> (state_reg == ST_OFF && !analog_o.power && !csr_reg.on);
   endproperty
   a_off_powers_down: assert property (p_off_powers_down) else $error("off yet active");

   property p_continuous;
      (end_conv && on_next && !halt_i) |=> (state_reg == ST_SAMPLE && cnt_reg == '0);
   endproperty
   a_continuous: assert property (p_continuous) else $error("no next conversion");

   property p_channel_restart;
      (ch_change && go) |=> (state_reg == ST_SAMPLE && !csr_reg.done && cnt_reg == '0);
   endproperty
   a_channel_restart: assert property (p_channel_restart) else $error("no restart");

   property p_slow_tick;
      (tick && !csr_reg.fast && !restart) |=> (!tick || csr_reg.fast) [*3];
   endproperty
   a_slow_tick: assert property (p_slow_tick) else $error("slow tick spacing");

   property p_fast_tick;
      (tick && csr_reg.fast && fast_next && !restart) |=> !tick;
   endproperty
   a_fast_tick: assert property (p_fast_tick) else $error("fast tick spacing");

   property p_high_view;
      s_high_read |-> s_read_back;
   endproperty
   a_high_view: assert property (p_high_view) else $error("high view wrong");

   property p_low_zero;
      (access_first && !pwrite_i && hit_low) |=> (prdata_o[31:2] == '0);
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low upper bits set");

   property p_stab_holds;
      (stab_reg != '0) |=> !analog_o.power;
   endproperty
   a_stab_holds: assert property (p_stab_holds) else $error("ran during stabilisation");

   property p_stab_len;
      $fell(halt_i) |-> (stab_reg == STAB_W'(STAB_LEN));
   endproperty
   a_stab_len: assert property (p_stab_len) else $error("stabilisation count wrong");

endmodule

// *** verification/adsc_core_model.sv ***
`timescale 1ns/1ps
// Behavioural input multiplexer and converter core for the bench.
module adsc_core_model
   import adsc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire adsc_analog_t analog_i,
   input wire logic [RES_BITS-1:0] level_i,
   output logic [RES_BITS-1:0] core_data_o
);
   // Selected input level; each channel reads the bench level plus its own number.
   logic [RES_BITS:0] sum;
   assign sum = {1'b0, level_i} + (RES_BITS + 1)'(analog_i.channel);

   // The core result follows the selected input while powered.
   // Unpowered, the bits toggle every cycle so that a stale value is never mistaken for data.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         core_data_o <= 10'h000;
      end else if (analog_i.power) begin
         core_data_o <= sum[RES_BITS] ? 10'h3FF : sum[RES_BITS-1:0];
      end else begin
         core_data_o <= ~core_data_o;
      end
   end
endmodule

// *** verification/adsc_ctrl_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the converter sequencing control block.
module adsc_ctrl_tb;
   import adsc_pkg::*;
   // Byte addresses of the registers and of one hole in the map.
   localparam logic [11:0] A_CSR = {CSR_IDX, 2'b00};
   localparam logic [11:0] A_HI = {RES_HIGH_IDX, 2'b00};
   localparam logic [11:0] A_LO = {RES_LOW_IDX, 2'b00};
   localparam logic [11:0] A_BAD = 12'h1CC;
   logic clock_i = 1'b0; // System clock.
   logic rst_b_i = 1'b0; // Reset, active low.
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic halt = 1'b0; // Halt request.
   logic [9:0] level = 10'h2A5; // Analog level applied by the bench.
   logic [9:0] core_data;
   adsc_analog_t analog;
   int bad_count = 0;
   int n_tests = 0;
   logic [31:0] rd; // Last read data.
   logic err; // Last error response.

   // Short stabilisation count keeps the halt scenario brief.
   adsc_ctrl #(.STAB_LEN(3)) i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .halt_i(halt),
      .core_data_i(core_data), .analog_o(analog));
   adsc_core_model i_core (.clock_i(clock_i), .rst_b_i(rst_b_i), .analog_i(analog),
      .level_i(level), .core_data_o(core_data));

   // The clock toggles every half period of 4 ns.
   always #4 clock_i = ~clock_i;

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One APB transfer; the free edge first keeps psel from being driven twice in a step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Polls the control/status register until the completion flag shows.
   task automatic wait_done();
      int k = 0;
      apb(1'b0, A_CSR, 32'h0);
      while (rd[7] !== 1'b1 && k < 200) begin
         apb(1'b0, A_CSR, 32'h0);
         k++;
      end
      chk({31'h0, rd[7]}, 32'h1, "completion flag");
   endtask

   // Reads low then high, as a ten-bit reader must, and checks both halves.
   task automatic rd_res(input logic [9:0] exp);
      apb(1'b0, A_LO, 32'h0);
      chk(rd, {30'h0, exp[1:0]}, "result low");
      apb(1'b0, A_HI, 32'h0);
      chk(rd, {24'h0, exp[9:2]}, "result high");
   endtask

   // Every register reads zero after reset.
   task automatic t_reset();
      apb(1'b0, A_CSR, 32'h0);
      chk(rd, 32'h0, "control after reset");
      apb(1'b0, A_HI, 32'h0);
      chk(rd, 32'h0, "high after reset");
      apb(1'b0, A_LO, 32'h0);
      chk(rd, 32'h0, "low after reset");
      $display("Test reset done");
   endtask

   // Every channel code; each write restarts conversion on the new input.
   task automatic t_channels();
      for (int ch = 0; ch < 16; ch++) begin
         // A pending flag first, so that the channel write has one to clear.
         if (ch > 0) begin
            wait_done();
         end
         apb(1'b1, A_CSR, 32'h60 | ch);
         apb(1'b0, A_CSR, 32'h0);
         chk(rd, 32'h60 | ch, "flag after channel change");
         wait_done();
         chk({28'h0, analog.channel}, ch, "mux select");
         rd_res(level + 10'(ch));
         apb(1'b0, A_CSR, 32'h0);
         chk({31'h0, rd[7]}, 32'h0, "flag after high read");
      end
      $display("Test channels done");
   endtask

   // Control writes clear the flag and cannot set it; results are overwritten unread.
   task automatic t_flag();
      apb(1'b1, A_CSR, 32'h65);
      wait_done();
      apb(1'b1, A_CSR, 32'hE5);
      apb(1'b0, A_CSR, 32'h0);
      chk(rd, 32'h65, "flag after control write");
      level <= 10'h155;
      repeat (120) @(posedge clock_i);
      rd_res(10'h15A);
      $display("Test flag done");
   endtask

   // Measures the converter clock period for one speed setting.
   task automatic speed_case(input logic [7:0] csr, input int exp);
      int n = 0;
      apb(1'b1, A_CSR, {24'h0, csr});
      repeat (8) @(posedge clock_i);
      // Start from a low level so that the count begins at a rising edge.
      while (analog.adc_clk !== 1'b0) @(posedge clock_i);
      while (analog.adc_clk !== 1'b1) @(posedge clock_i);
      do begin
         @(posedge clock_i);
         n++;
      end while (analog.adc_clk !== 1'b0);
      do begin
         @(posedge clock_i);
         n++;
      end while (analog.adc_clk !== 1'b1);
      chk(32'(n), 32'(exp), "converter clock period");
   endtask

   // Both clock divides.
   task automatic t_speed();
      speed_case(8'h25, 4);
      speed_case(8'h65, 2);
      $display("Test speed done");
   endtask

   // Levels beyond the upper reference and at the lower one.
   task automatic t_range();
      level <= 10'h3FF;
      apb(1'b1, A_CSR, 32'h6F);
      wait_done();
      rd_res(10'h3FF);
      level <= 10'h000;
      apb(1'b1, A_CSR, 32'h60);
      wait_done();
      rd_res(10'h000);
      $display("Test range done");
   endtask

   // Switching off keeps the result; the high result register refuses a write and a hole answers a read with an error.
   task automatic t_off();
      level <= 10'h2C3;
      apb(1'b1, A_CSR, 32'h65);
      wait_done();
      apb(1'b1, A_CSR, 32'h45);
      repeat (3) @(posedge clock_i);
      for (int i = 0; i < 60; i++) begin
         @(posedge clock_i);
         chk({30'h0, analog.power, analog.sample}, 32'h0, "power while off");
      end
      apb(1'b1, A_HI, 32'hAA);
      rd_res(10'h2C8);
      apb(1'b0, A_BAD, 32'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped read");
      apb(1'b0, A_CSR, 32'h0);
      chk(rd, 32'h45, "control while off");
      $display("Test off done");
   endtask

   // Halt stops the converter; it waits out stabilisation before running again.
   task automatic t_halt();
      int k = 0;
      apb(1'b1, A_CSR, 32'h65);
      wait_done();
      // Clearing the flag here makes the wait after wake-up need a fresh result.
      apb(1'b0, A_HI, 32'h0);
      halt <= 1'b1;
      repeat (4) @(posedge clock_i);
      chk({31'h0, analog.power}, 32'h0, "power in halt");
      halt <= 1'b0;
      repeat (3) begin
         @(posedge clock_i);
         chk({31'h0, analog.power}, 32'h0, "power while stabilising");
      end
      while (analog.power !== 1'b1 && k < 40) begin
         @(posedge clock_i);
         k++;
      end
      chk({31'h0, analog.power}, 32'h1, "power after wake");
      wait_done();
      $display("Test halt done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence: eight cycles of reset, then every scenario in turn.
   initial begin
      repeat (8) @(posedge clock_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_channels();
      t_flag();
      t_speed();
      t_range();
      t_off();
      t_halt();
      give_verdict();
   end

   // Watchdog: the scenarios need a few thousand cycles, so this span means a hang.
   initial begin
      repeat (60000) @(posedge clock_i);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
